// ### chip_reset_defs.svh
// Constants for the chip reset and clock strap block.
`ifndef CHIP_RESET_DEFS_SVH
`define CHIP_RESET_DEFS_SVH

// Clock figures in MHz and ps.
`define REFERENCE_CLOCK_MHZ 25
`define SYSTEM_CLOCK_MHZ 125
`define CORE_CLOCK_PERIOD_PS 5000
`define SYSTEM_CLOCK_PERIOD_PS 8000

// Least hold of the chip reset input, in system clock cycles.
`define CHIP_RESET_MIN_SYS_CYCLES 256

// Least assertion of the system reset output, in ms.
`define RESET_OUT_MIN_MS 200
`define PS_PER_MS 1_000_000_000

// Strap codes.
`define CPU_CLOCK_STRAP_PLL 1'h0
`define CPU_CLOCK_STRAP_RESERVED 1'h1
`define RESET_OUT_STRAP_HIGH 1'h0
`define RESET_OUT_STRAP_LOW 1'h1

// Pin output enable levels, low while driving.
`define PIN_DRIVE 1'h0
`define PIN_FLOAT 1'h1

`endif

// ### chip_reset_pkg.sv
// Types shared by the chip reset and clock strap block.
package chip_reset_pkg;

    // Phase of the chip as seen by the reset input.
    typedef enum logic {
        PHASE_CHIP_RESET,
        PHASE_RUN
    } phase_t;

    // Source of the CPU clock chosen by the strap.
    typedef enum logic {
        CPU_CLOCK_FROM_PLL,
        CPU_CLOCK_FACTORY_TEST
    } cpu_clock_source_t;

endpackage : chip_reset_pkg

// ### chip_reset_and_clock_straps.sv
// Chip reset sequencing, strap capture and shared strap pin control.
`timescale 1ns/1ps
`include "chip_reset_defs.svh"

module chip_reset_and_clock_straps #(
    parameter int unsigned RESET_OUT_CYCLES =
        (`RESET_OUT_MIN_MS * (`PS_PER_MS / `CORE_CLOCK_PERIOD_PS)),
    parameter int unsigned CHIP_RESET_MIN_CYCLES =
        (`CHIP_RESET_MIN_SYS_CYCLES * `SYSTEM_CLOCK_PERIOD_PS + `CORE_CLOCK_PERIOD_PS - 1)
        / `CORE_CLOCK_PERIOD_PS
) (
    // Clock and block reset.
    input wire logic i_core_clk,
    input wire logic i_reset,
    // Board reset and watchdog.
    input wire logic i_chip_reset_in_n,
    input wire logic i_watchdog_expired,
    // Reference clock presence from the clock pad.
    input wire logic i_reference_clock_in,
    // Shared pin: CPU clock strap and UART request-to-send.
    input wire logic i_cpu_clock_source_strap,
    input wire logic i_uart_rts_request_n,
    output logic o_uart_request_to_send_n,
    output logic o_uart_request_to_send_oe_n,
    // Shared pin: reset polarity strap and static memory output enable.
    input wire logic i_reset_out_polarity_strap,
    input wire logic i_static_mem_oe_request_n,
    output logic o_static_mem_output_enable_n,
    output logic o_static_mem_output_enable_oe_n,
    // System reset output pin.
    output logic o_system_reset_out,
    output logic o_system_reset_out_oe_n,
    // Core reset and clock selection.
    output logic o_core_reset,
    output logic o_cpu_clock_from_pll,
    output logic o_pll_enable,
    output logic [7:0] o_pll_multiplier,
    // Status.
    output logic o_chip_reset_hold_met,
    output logic o_reference_clock_seen
);

    localparam int unsigned HOLD_W = $clog2(RESET_OUT_CYCLES + 1);
    localparam int unsigned MIN_W = $clog2(CHIP_RESET_MIN_CYCLES + 1);
    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(RESET_OUT_CYCLES);
    localparam logic [MIN_W-1:0] MIN_LOAD = MIN_W'(CHIP_RESET_MIN_CYCLES);
    localparam logic [7:0] PLL_RATIO = 8'(`SYSTEM_CLOCK_MHZ / `REFERENCE_CLOCK_MHZ);

    // Gives the pin level of the system reset output for a given polarity strap.
    function automatic logic reset_out_level(input logic asserted, input logic strap);
        if (strap == `RESET_OUT_STRAP_LOW) begin
            reset_out_level = ~asserted;
        end else begin
            reset_out_level = asserted;
        end
    endfunction : reset_out_level

    // Phase and strap state.
    chip_reset_pkg::phase_t phase;
    chip_reset_pkg::phase_t next_phase;
    chip_reset_pkg::cpu_clock_source_t cpu_clock_source;
    chip_reset_pkg::cpu_clock_source_t next_cpu_clock_source;
    logic reset_out_strap;
    logic next_reset_out_strap;
    logic [MIN_W-1:0] low_count;
    logic [MIN_W-1:0] next_low_count;
    logic hold_met;
    logic next_hold_met;
    logic ref_prev;
    logic next_ref_prev;
    logic ref_seen;
    logic next_ref_seen;

    // Reset output stretch state.
    logic [HOLD_W-1:0] hold_count;
    logic [HOLD_W-1:0] next_hold_count;

    // Registered pin and core outputs.
    logic next_uart_rts_n;
    logic next_uart_rts_oe_n;
    logic next_mem_oe_n;
    logic next_mem_oe_oe_n;
    logic next_sys_reset_out;
    logic next_sys_reset_oe_n;
    logic next_core_reset;
    logic next_cpu_from_pll;
    logic next_pll_enable;

    // Phase tracking, strap capture and reset hold check.
    always_comb begin
        next_phase = phase;
        next_cpu_clock_source = cpu_clock_source;
        next_reset_out_strap = reset_out_strap;
        next_low_count = low_count;
        next_hold_met = hold_met;
        next_ref_prev = i_reference_clock_in;
        next_ref_seen = ref_seen | (i_reference_clock_in ^ ref_prev);
        unique case (phase)
            chip_reset_pkg::PHASE_CHIP_RESET: begin
                if (low_count != MIN_LOAD) begin
                    next_low_count = low_count + MIN_W'(1);
                end
                if (low_count == MIN_LOAD) begin
                    next_hold_met = 1'b1;
                end
                if (i_chip_reset_in_n) begin
                    next_phase = chip_reset_pkg::PHASE_RUN;
                    if (i_cpu_clock_source_strap == `CPU_CLOCK_STRAP_PLL) begin
                        next_cpu_clock_source = chip_reset_pkg::CPU_CLOCK_FROM_PLL;
                    end else begin
                        next_cpu_clock_source = chip_reset_pkg::CPU_CLOCK_FACTORY_TEST;
                    end
                    next_reset_out_strap = i_reset_out_polarity_strap;
                end
            end
            chip_reset_pkg::PHASE_RUN: begin
                if (!i_chip_reset_in_n) begin
                    next_phase = chip_reset_pkg::PHASE_CHIP_RESET;
                    next_low_count = MIN_W'(1);
                    next_hold_met = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            phase <= chip_reset_pkg::PHASE_CHIP_RESET;
            cpu_clock_source <= chip_reset_pkg::CPU_CLOCK_FROM_PLL;
            reset_out_strap <= `RESET_OUT_STRAP_HIGH;
            low_count <= '0;
            hold_met <= 1'b0;
            ref_prev <= 1'b0;
            ref_seen <= 1'b0;
        end else begin
            phase <= next_phase;
            cpu_clock_source <= next_cpu_clock_source;
            reset_out_strap <= next_reset_out_strap;
            low_count <= next_low_count;
            hold_met <= next_hold_met;
            ref_prev <= next_ref_prev;
            ref_seen <= next_ref_seen;
        end
    end

    // Reset output stretch counter.
    always_comb begin
        next_hold_count = hold_count;
        if (!i_chip_reset_in_n || i_watchdog_expired) begin
            next_hold_count = HOLD_LOAD;
        end else if (hold_count != '0) begin
            next_hold_count = hold_count - HOLD_W'(1);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            hold_count <= HOLD_LOAD;
        end else begin
            hold_count <= next_hold_count;
        end
    end

    // Pin, core reset and clock select outputs.
    always_comb begin
        next_core_reset = !i_chip_reset_in_n || i_watchdog_expired;
        next_pll_enable = 1'b1;
        next_cpu_from_pll = (cpu_clock_source == chip_reset_pkg::CPU_CLOCK_FROM_PLL);
        next_sys_reset_oe_n = `PIN_DRIVE;
        if (!i_chip_reset_in_n || phase == chip_reset_pkg::PHASE_CHIP_RESET) begin
            next_uart_rts_n = 1'b1;
            next_uart_rts_oe_n = `PIN_FLOAT;
            next_mem_oe_n = 1'b1;
            next_mem_oe_oe_n = `PIN_FLOAT;
            next_cpu_from_pll = (i_cpu_clock_source_strap == `CPU_CLOCK_STRAP_PLL);
            next_sys_reset_out = reset_out_level(1'b1, i_reset_out_polarity_strap);
        end else begin
            next_uart_rts_n = i_uart_rts_request_n;
            next_uart_rts_oe_n = `PIN_DRIVE;
            next_mem_oe_n = i_static_mem_oe_request_n;
            next_mem_oe_oe_n = `PIN_DRIVE;
            next_sys_reset_out =
                reset_out_level(next_hold_count != '0, reset_out_strap);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_uart_request_to_send_n <= 1'b1;
            o_uart_request_to_send_oe_n <= `PIN_FLOAT;
            o_static_mem_output_enable_n <= 1'b1;
            o_static_mem_output_enable_oe_n <= `PIN_FLOAT;
            o_system_reset_out <= 1'b1;
            o_system_reset_out_oe_n <= `PIN_FLOAT;
            o_core_reset <= 1'b1;
            o_cpu_clock_from_pll <= 1'b1;
            o_pll_enable <= 1'b0;
            o_pll_multiplier <= PLL_RATIO;
            o_chip_reset_hold_met <= 1'b0;
            o_reference_clock_seen <= 1'b0;
        end else begin
            o_uart_request_to_send_n <= next_uart_rts_n;
            o_uart_request_to_send_oe_n <= next_uart_rts_oe_n;
            o_static_mem_output_enable_n <= next_mem_oe_n;
            o_static_mem_output_enable_oe_n <= next_mem_oe_oe_n;
            o_system_reset_out <= next_sys_reset_out;
            o_system_reset_out_oe_n <= next_sys_reset_oe_n;
            o_core_reset <= next_core_reset;
            o_cpu_clock_from_pll <= next_cpu_from_pll;
            o_pll_enable <= next_pll_enable;
            o_pll_multiplier <= PLL_RATIO;
            o_chip_reset_hold_met <= next_hold_met;
            o_reference_clock_seen <= next_ref_seen;
        end
    end

endmodule : chip_reset_and_clock_straps

// ### chip_reset_and_clock_straps_properties.sv
// Checker for the chip reset and clock strap block.
`timescale 1ns/1ps
module chip_reset_and_clock_straps_properties (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_chip_reset_in_n,
    input wire logic i_watchdog_expired,
    input wire logic i_cpu_clock_source_strap,
    input wire logic i_uart_rts_request_n,
    input wire logic o_uart_request_to_send_n,
    input wire logic o_uart_request_to_send_oe_n,
    input wire logic i_reset_out_polarity_strap,
    input wire logic o_static_mem_output_enable_oe_n,
    input wire logic o_system_reset_out,
    input wire logic o_core_reset,
    input wire logic o_cpu_clock_from_pll
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    pins_float_a:
    assert property (!i_chip_reset_in_n |=>
        o_uart_request_to_send_oe_n && o_static_mem_output_enable_oe_n)
        else $error("pin not floating");
    pins_drive_a:
    assert property (i_chip_reset_in_n[*2] |=>
        !o_uart_request_to_send_oe_n && !o_static_mem_output_enable_oe_n)
        else $error("pin not driven");
    rts_follow_a:
    assert property (i_chip_reset_in_n[*3] |=>
        o_uart_request_to_send_n == $past(i_uart_rts_request_n))
        else $error("rts wrong");
    core_reset_a:
    assert property (!i_chip_reset_in_n || i_watchdog_expired |=> o_core_reset)
        else $error("core reset missing");
    reset_hold_a:
    assert property (i_watchdog_expired ##1 1 |=> $stable(o_system_reset_out)[*8])
        else $error("reset out too short");
    reset_level_a:
    assert property ((!i_chip_reset_in_n)[*4] |=>
        o_system_reset_out == !$past(i_reset_out_polarity_strap))
        else $error("reset out level");
    cpu_source_a:
    assert property ((!i_chip_reset_in_n)[*4] |=>
        o_cpu_clock_from_pll == !$past(i_cpu_clock_source_strap))
        else $error("cpu clock source");
    strap_hold_a:
    assert property (i_chip_reset_in_n[*3] |=> $stable(o_cpu_clock_from_pll))
        else $error("strap changed");
endmodule : chip_reset_and_clock_straps_properties

bind chip_reset_and_clock_straps chip_reset_and_clock_straps_properties i_props (
    .i_core_clk, .i_reset, .i_chip_reset_in_n, .i_watchdog_expired, .i_cpu_clock_source_strap,
    .i_uart_rts_request_n, .o_uart_request_to_send_n, .o_uart_request_to_send_oe_n,
    .i_reset_out_polarity_strap, .o_static_mem_output_enable_oe_n, .o_system_reset_out,
    .o_core_reset, .o_cpu_clock_from_pll);

// ### board_reset_model.sv
// Board reset circuit and strap resistors on the shared pins.
`timescale 1ns/1ps
module board_reset_model (
    input wire logic i_clk,
    input wire logic i_rts_n,
    input wire logic i_rts_oe_n,
    input wire logic i_mem_n,
    input wire logic i_mem_oe_n,
    output logic o_reset_n,
    output logic o_cpu_wire,
    output logic o_pol_wire
);
    logic cpu_pull = 1'h0;
    logic pol_pull = 1'h0;
    initial o_reset_n = 1'h1;
    // A floating pin settles at its strap resistor level.
    assign o_cpu_wire = i_rts_oe_n ? cpu_pull : i_rts_n;
    assign o_pol_wire = i_mem_oe_n ? pol_pull : i_mem_n;
    task automatic hold_reset(input int n, input logic cpu, input logic pol);
        @(negedge i_clk);
        cpu_pull = cpu;
        pol_pull = pol;
        o_reset_n = 1'h0;
        repeat (n) @(negedge i_clk);
        o_reset_n = 1'h1;
    endtask : hold_reset
endmodule : board_reset_model

// ### chip_reset_and_clock_straps_test.sv
// Self-checking testbench for the chip reset and clock strap block.
`timescale 1ns/1ps
module chip_reset_and_clock_straps_test;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic wd = 1'h0;
    logic ref_in = 1'h0;
    logic rts_req = 1'h1;
    logic mem_req = 1'h1;
    logic pol = 1'h0;
    logic chip_n, cpu_w, pol_w, rts_n, rts_oe, mem_n, mem_oe, sys, core, pll, en, met, seen;
    logic sys_oe;
    logic [7:0] mult;
    int num_errors = 0;
    int samples_checked = 0;
    always #2.5 clk = ~clk;
    board_reset_model i_board (.i_clk(clk), .i_rts_n(rts_n), .i_rts_oe_n(rts_oe), .i_mem_n(mem_n),
        .i_mem_oe_n(mem_oe), .o_reset_n(chip_n), .o_cpu_wire(cpu_w), .o_pol_wire(pol_w));
    chip_reset_and_clock_straps #(.RESET_OUT_CYCLES(20), .CHIP_RESET_MIN_CYCLES(8))
    i_chip_reset_and_clock_straps (.i_core_clk(clk), .i_reset(rst), .i_chip_reset_in_n(chip_n),
        .i_watchdog_expired(wd), .i_reference_clock_in(ref_in), .i_cpu_clock_source_strap(cpu_w),
        .i_uart_rts_request_n(rts_req), .o_uart_request_to_send_n(rts_n),
        .o_uart_request_to_send_oe_n(rts_oe), .i_reset_out_polarity_strap(pol_w),
        .i_static_mem_oe_request_n(mem_req), .o_static_mem_output_enable_n(mem_n),
        .o_static_mem_output_enable_oe_n(mem_oe), .o_system_reset_out(sys),
        .o_system_reset_out_oe_n(sys_oe), .o_core_reset(core), .o_cpu_clock_from_pll(pll),
        .o_pll_enable(en), .o_pll_multiplier(mult), .o_chip_reset_hold_met(met),
        .o_reference_clock_seen(seen));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task end_of_test;
        $display("Checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    task t_pll;
        chk(seen, 1'h0);
        ref_in = 1'h1;
        repeat (2) @(negedge clk);
        chk({seen, en, mult}, 10'h305);
    endtask : t_pll
    task t_float;
        fork
            i_board.hold_reset(7, 1'h0, 1'h0);
            begin
                repeat (3) @(negedge clk);
                chk({rts_oe, mem_oe, core, sys_oe}, 4'hE);
            end
        join
        @(negedge clk);
        chk(met, 1'h0);
        i_board.hold_reset(8, 1'h0, 1'h0);
        @(negedge clk);
        chk(met, 1'h1);
    endtask : t_float
    task t_straps;
        for (int s = 0; s < 4; s++) begin
            i_board.hold_reset(10, s[0], s[1]);
            pol = s[1];
            repeat (3) @(negedge clk);
            chk({pll, sys}, {!s[0], !pol});
            rts_req = 1'h0;
            mem_req = 1'h0;
            repeat (2) @(negedge clk);
            chk({rts_n, mem_n, rts_oe, mem_oe, pll}, {4'h0, !s[0]});
            rts_req = 1'h1;
            mem_req = 1'h1;
            repeat (20) @(negedge clk);
            chk({rts_n, mem_n, sys, pll}, {2'h3, pol, !s[0]});
        end
    endtask : t_straps
    task t_watchdog;
        wd = 1'h1;
        @(negedge clk);
        chk({core, sys}, {1'h1, !pol});
        wd = 1'h0;
        repeat (19) @(negedge clk);
        chk(sys, !pol);
        @(negedge clk);
        chk({core, sys}, {1'h0, pol});
    endtask : t_watchdog
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'h0;
        repeat (2) @(negedge clk);
        t_pll;
        t_float;
        t_straps;
        t_watchdog;
        end_of_test;
    end
    initial begin
        repeat (2000) @(posedge clk);
        num_errors++;
        end_of_test;
    end
endmodule : chip_reset_and_clock_straps_test
